/* logic/oscl_pkg.sv */
package oscl_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OSCL_ADR_CFG = 8'h00;
  localparam logic [7:0] OSCL_ADR_ESTOP = 8'h04;
  localparam logic [7:0] OSCL_ADR_CTRL = 8'h08;
  localparam logic [7:0] OSCL_ADR_STATUS = 8'h0C;
  localparam logic [7:0] OSCL_ADR_ACTIVE = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OSCL_CFG_FWD_LSB = 0;
  localparam int OSCL_CFG_REV_LSB = 4;
  localparam int OSCL_CFG_METH_LSB = 8;
  localparam int OSCL_CFG_DIR_BIT = 16;
  localparam int OSCL_CTRL_RESTART_BIT = 0;
  localparam int OSCL_ST_FWD_BIT = 0;
  localparam int OSCL_ST_REV_BIT = 1;
  localparam int OSCL_ST_STATE_LSB = 2;

  // ----------------------------------------------------------------
  // setting codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OSCL_FWD_SEL_USE = 4'h1;
  localparam logic [3:0] OSCL_REV_SEL_USE = 4'h2;
  localparam logic [3:0] OSCL_SEL_IGNORE = 4'h8;
  localparam logic [7:0] OSCL_METH_DB = 8'h00;
  localparam logic [7:0] OSCL_METH_DB_COAST = 8'h01;
  localparam logic [7:0] OSCL_METH_COAST = 8'h02;
  localparam logic [7:0] OSCL_METH_DEC_CLAMP = 8'h10;
  localparam logic [7:0] OSCL_METH_DEC_COAST = 8'h20;
  localparam logic [3:0] OSCL_DIGIT_COAST = 4'h2;
  localparam logic OSCL_DIR_RST = 1'b0;
  localparam logic [9:0] OSCL_ESTOP_MAX = 10'h320;
  localparam logic [9:0] OSCL_ESTOP_RST = 10'h320;

  // ----------------------------------------------------------------
  // motion constants
  // ----------------------------------------------------------------
  localparam logic signed [15:0] OSCL_STOP_THR = 16'sh0010;
  localparam int OSCL_CLAMP_KP_SHIFT = 2;

  typedef enum logic [2:0] {
    OSCL_ST_RUN = 3'h0,
    OSCL_ST_DB = 3'h1,
    OSCL_ST_COAST = 3'h2,
    OSCL_ST_DECEL = 3'h3,
    OSCL_ST_DB_HOLD = 3'h4,
    OSCL_ST_COAST_HOLD = 3'h5,
    OSCL_ST_CLAMP = 3'h6
  } oscl_state_t;

endpackage

/* logic/oscl_sync.sv */
module oscl_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);
  import oscl_pkg::*;

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] held;
  } oscl_sync_regs_t;

  oscl_sync_regs_t r_ff;
  oscl_sync_regs_t nxt_r;

  // limit switches idle high (motion allowed), so reset to that level
  always_comb begin
    nxt_r.meta = async_in;
    nxt_r.held = r_ff.meta;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= {4'hF, 4'hF};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign sync_out = r_ff.held;
endmodule

/* logic/oscl_top.sv */
// Function
// [R01] forward limit off flags forward overtravel
// [R02] reverse limit off flags reverse overtravel
// [R03] opposite-direction reference accepted during overtravel
// [R04] forward select 1 uses, 8 ignores
// [R05] reverse select 2 uses, 8 ignores
// [R06] stop method chosen by code after restart
// [R07] dynamic brake shorts motor for quick stop
// [R08] deceleration uses emergency stop force
// [R09] zero clamp holds position loop at zero
// [R10] coast applies no control at all
// [R11] force control never decelerates, coasts after stop
// [R12] reversal flips motion, encoder polarity unchanged
// [R13] configure motor phase before reversing direction
// [R14] stop force 0..800 percent, capped at maximum
// [R15] limit inputs synchronised before use
module oscl_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  output logic enc_a_out,
  output logic enc_b_out,
  input wire logic signed [15:0] ref_velocity,
  input wire logic signed [15:0] fb_velocity,
  input wire logic signed [31:0] fb_position,
  input wire logic force_control,
  input wire logic [9:0] motor_max_force,
  output logic signed [15:0] cmd_velocity,
  output logic dynamic_brake_stop,
  output logic coast_on,
  output logic decel_active,
  output logic [9:0] decel_force,
  output logic zero_clamp_on,
  output logic fwd_overtravel,
  output logic rev_overtravel
);
  import oscl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] fwd_sel;
    logic [3:0] rev_sel;
    logic [7:0] method;
    logic dir_rev;
    logic [3:0] act_fwd;
    logic [3:0] act_rev;
    logic [7:0] act_method;
    logic act_dir;
    logic [9:0] estop;
    oscl_state_t st;
    logic fwd_ot;
    logic rev_ot;
    logic signed [31:0] clamp_pos;
    logic signed [15:0] cmd;
    logic [9:0] dforce;
    logic enc_a;
    logic enc_b;
    logic ack;
    logic [31:0] dat;
  } oscl_regs_t;

  localparam oscl_regs_t RST_VAL = '{
    fwd_sel: OSCL_FWD_SEL_USE, rev_sel: OSCL_REV_SEL_USE, method: OSCL_METH_DB,
    dir_rev: OSCL_DIR_RST, act_fwd: OSCL_FWD_SEL_USE, act_rev: OSCL_REV_SEL_USE,
    act_method: OSCL_METH_DB, act_dir: OSCL_DIR_RST, estop: OSCL_ESTOP_RST,
    st: OSCL_ST_RUN, fwd_ot: 1'b0, rev_ot: 1'b0, clamp_pos: 32'sh0, cmd: 16'sh0,
    dforce: 10'h0, enc_a: 1'b0, enc_b: 1'b0, ack: 1'b0, dat: 32'h0};

  oscl_regs_t r_ff;
  oscl_regs_t nxt_r;
  logic [3:0] pins_sync;

  oscl_sync u_sync ( // [R15]
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({enc_b_in, enc_a_in, reverse_limit_input, forward_limit_input}),
    .sync_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] neg_sat(input logic signed [15:0] v);
    neg_sat = (v == 16'sh8000) ? 16'sh7FFF : -v;
  endfunction

  function automatic logic signed [15:0] dir_apply(input logic signed [15:0] v,
                                                   input logic rev);
    dir_apply = rev ? neg_sat(v) : v;
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sh7FFF) begin
      sat16 = 16'sh7FFF;
    end else if (v < -34'sh8000) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // unknown codes fall back to the safest choice, the dynamic brake, except under force control with a low digit of 2
  function automatic oscl_state_t stop_entry(input logic [7:0] m, input logic frc);
    if (frc) begin
      stop_entry = (m[3:0] == OSCL_DIGIT_COAST) ? OSCL_ST_COAST : OSCL_ST_DB; // [R11]
    end else begin
      case (m)
        OSCL_METH_COAST: stop_entry = OSCL_ST_COAST;
        OSCL_METH_DEC_CLAMP: stop_entry = OSCL_ST_DECEL;
        OSCL_METH_DEC_COAST: stop_entry = OSCL_ST_DECEL;
        default: stop_entry = OSCL_ST_DB;
      endcase
    end
  endfunction

  function automatic oscl_state_t stop_hold(input logic [7:0] m, input logic frc);
    if (frc) begin
      stop_hold = OSCL_ST_COAST_HOLD; // [R11]
    end else begin
      // unknown codes keep behaving as code 00 after the stop as well
      case (m)
        OSCL_METH_DB_COAST: stop_hold = OSCL_ST_COAST_HOLD;
        OSCL_METH_COAST: stop_hold = OSCL_ST_COAST_HOLD;
        OSCL_METH_DEC_COAST: stop_hold = OSCL_ST_COAST_HOLD;
        OSCL_METH_DEC_CLAMP: stop_hold = OSCL_ST_CLAMP;
        default: stop_hold = OSCL_ST_DB_HOLD;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------------
  logic req;
  logic [7:0] adr;
  logic [9:0] est;
  logic use_fwd;
  logic use_rev;
  logic signed [15:0] fb_ref;
  logic ref_fwd;
  logic ref_rev;
  logic away;
  logic trip;
  logic stopped;
  logic signed [33:0] perr;

  always_comb begin
    nxt_r = r_ff;
    req = wb_cyc_i && wb_stb_i && !r_ff.ack;
    adr = {wb_adr_i[7:2], 2'b00};
    est = r_ff.estop;
    nxt_r.ack = req;
    nxt_r.dat = 32'h0;

    // bus writes; the restart strobe promotes the staged settings
    if (req && wb_we_i) begin
      case (adr)
        OSCL_ADR_CFG: begin
          if (wb_sel_i[0]) begin
            nxt_r.fwd_sel = wb_dat_i[OSCL_CFG_FWD_LSB +: 4];
            nxt_r.rev_sel = wb_dat_i[OSCL_CFG_REV_LSB +: 4];
          end
          if (wb_sel_i[1]) begin
            nxt_r.method = wb_dat_i[OSCL_CFG_METH_LSB +: 8];
          end
          if (wb_sel_i[2]) begin
            nxt_r.dir_rev = wb_dat_i[OSCL_CFG_DIR_BIT];
          end
        end
        OSCL_ADR_ESTOP: begin
          if (wb_sel_i[0]) begin
            est[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            est[9:8] = wb_dat_i[9:8];
          end
          nxt_r.estop = (est > OSCL_ESTOP_MAX) ? OSCL_ESTOP_MAX : est; // [R14]
        end
        OSCL_ADR_CTRL: begin
          if (wb_sel_i[0] && wb_dat_i[OSCL_CTRL_RESTART_BIT]) begin
            nxt_r.act_fwd = r_ff.fwd_sel; // [R04]
            nxt_r.act_rev = r_ff.rev_sel; // [R05]
            nxt_r.act_method = r_ff.method; // [R06]
            nxt_r.act_dir = r_ff.dir_rev;
          end
        end
        default: begin
        end
      endcase
    end
    if (req && !wb_we_i) begin
      case (adr)
        OSCL_ADR_CFG: begin
          nxt_r.dat[OSCL_CFG_FWD_LSB +: 4] = r_ff.fwd_sel;
          nxt_r.dat[OSCL_CFG_REV_LSB +: 4] = r_ff.rev_sel;
          nxt_r.dat[OSCL_CFG_METH_LSB +: 8] = r_ff.method;
          nxt_r.dat[OSCL_CFG_DIR_BIT] = r_ff.dir_rev;
        end
        OSCL_ADR_ESTOP: nxt_r.dat[9:0] = r_ff.estop;
        OSCL_ADR_STATUS: begin
          nxt_r.dat[OSCL_ST_FWD_BIT] = r_ff.fwd_ot;
          nxt_r.dat[OSCL_ST_REV_BIT] = r_ff.rev_ot;
          nxt_r.dat[OSCL_ST_STATE_LSB +: 3] = r_ff.st;
        end
        OSCL_ADR_ACTIVE: begin
          nxt_r.dat[OSCL_CFG_FWD_LSB +: 4] = r_ff.act_fwd;
          nxt_r.dat[OSCL_CFG_REV_LSB +: 4] = r_ff.act_rev;
          nxt_r.dat[OSCL_CFG_METH_LSB +: 8] = r_ff.act_method;
          nxt_r.dat[OSCL_CFG_DIR_BIT] = r_ff.act_dir;
        end
        default: nxt_r.dat = 32'h0;
      endcase
    end

    // limit evaluation in the reference frame; an open switch means stop
    use_fwd = (r_ff.act_fwd != OSCL_SEL_IGNORE); // [R04]
    use_rev = (r_ff.act_rev != OSCL_SEL_IGNORE); // [R05]
    nxt_r.fwd_ot = use_fwd && !pins_sync[0]; // [R01]
    nxt_r.rev_ot = use_rev && !pins_sync[1]; // [R02]

    // feedback is in motor frame, so undo the reversal before comparing
    fb_ref = dir_apply(fb_velocity, r_ff.act_dir); // [R12]
    ref_fwd = (ref_velocity > 16'sh0);
    ref_rev = (ref_velocity < 16'sh0);
    away = (ref_fwd && !r_ff.fwd_ot) || (ref_rev && !r_ff.rev_ot); // [R03]
    trip = (r_ff.fwd_ot && (ref_fwd || (!away && fb_ref > OSCL_STOP_THR))) ||
           (r_ff.rev_ot && (ref_rev || (!away && fb_ref < -OSCL_STOP_THR)));
    stopped = (fb_velocity <= OSCL_STOP_THR) && (fb_velocity >= -OSCL_STOP_THR);

    case (r_ff.st)
      OSCL_ST_RUN: begin
        if (trip) begin
          nxt_r.st = stop_entry(r_ff.act_method, force_control); // [R06]
        end
      end
      OSCL_ST_DB, OSCL_ST_COAST, OSCL_ST_DECEL: begin
        if (away) begin
          nxt_r.st = OSCL_ST_RUN; // [R03]
        end else if (stopped) begin
          nxt_r.st = stop_hold(r_ff.act_method, force_control);
        end
      end
      OSCL_ST_DB_HOLD, OSCL_ST_COAST_HOLD, OSCL_ST_CLAMP: begin
        if (away || (!r_ff.fwd_ot && !r_ff.rev_ot)) begin
          nxt_r.st = OSCL_ST_RUN; // [R03]
        end
      end
      default: nxt_r.st = OSCL_ST_DB;
    endcase

    // clamp target is the position where the axis came to rest
    if (nxt_r.st == OSCL_ST_CLAMP && r_ff.st != OSCL_ST_CLAMP) begin
      nxt_r.clamp_pos = fb_position; // [R09]
    end
    // use the new target so the first clamp cycle does not chase a stale position
    perr = {{2{nxt_r.clamp_pos[31]}}, nxt_r.clamp_pos} - {{2{fb_position[31]}}, fb_position};

    case (nxt_r.st)
      OSCL_ST_RUN: nxt_r.cmd = dir_apply(ref_velocity, r_ff.act_dir); // [R12]
      OSCL_ST_CLAMP: nxt_r.cmd = sat16(perr <<< OSCL_CLAMP_KP_SHIFT); // [R09]
      default: nxt_r.cmd = 16'sh0; // [R07] [R10]
    endcase

    // stage cannot give more than the motor maximum
    nxt_r.dforce = (r_ff.estop > motor_max_force) ? motor_max_force : r_ff.estop; // [R08]
    // encoder pulses pass straight through: reversal never touches them
    nxt_r.enc_a = pins_sync[2]; // [R12]
    nxt_r.enc_b = pins_sync[3]; // [R12]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= RST_VAL;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = r_ff.dat;
  assign wb_ack_o = r_ff.ack;
  assign enc_a_out = r_ff.enc_a;
  assign enc_b_out = r_ff.enc_b;
  assign cmd_velocity = r_ff.cmd;
  assign dynamic_brake_stop = (r_ff.st == OSCL_ST_DB) || (r_ff.st == OSCL_ST_DB_HOLD); // [R07]
  assign coast_on = (r_ff.st == OSCL_ST_COAST) || (r_ff.st == OSCL_ST_COAST_HOLD); // [R10]
  assign decel_active = (r_ff.st == OSCL_ST_DECEL); // [R08]
  assign decel_force = r_ff.dforce;
  assign zero_clamp_on = (r_ff.st == OSCL_ST_CLAMP); // [R09]
  assign fwd_overtravel = r_ff.fwd_ot;
  assign rev_overtravel = r_ff.rev_ot;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_fwd_blocks_run: assert property ( // [R01]
    (r_ff.st == OSCL_ST_RUN && r_ff.fwd_ot && ref_fwd) |=> r_ff.st != OSCL_ST_RUN)
    else $error("forward reference not stopped at forward limit");
  a_rev_blocks_run: assert property ( // [R02]
    (r_ff.st == OSCL_ST_RUN && r_ff.rev_ot && ref_rev) |=> r_ff.st != OSCL_ST_RUN)
    else $error("reverse reference not stopped at reverse limit");
  a_away_resumes: assert property ( // [R03]
    (r_ff.st != OSCL_ST_RUN && away) |=> (r_ff.st == OSCL_ST_RUN &&
      cmd_velocity == dir_apply($past(ref_velocity), $past(r_ff.act_dir))))
    else $error("reference away from limit not accepted");
  a_fwd_ignored: assert property ( // [R04]
    (r_ff.act_fwd == OSCL_SEL_IGNORE && $past(r_ff.act_fwd == OSCL_SEL_IGNORE))
      |-> !fwd_overtravel)
    else $error("ignored forward limit still flags overtravel");
  a_rev_ignored: assert property ( // [R05]
    (r_ff.act_rev == OSCL_SEL_IGNORE && $past(r_ff.act_rev == OSCL_SEL_IGNORE))
      |-> !rev_overtravel)
    else $error("ignored reverse limit still flags overtravel");
  a_decel_entry: assert property ( // [R06]
    (r_ff.st == OSCL_ST_RUN && trip && !force_control &&
     r_ff.act_method == OSCL_METH_DEC_CLAMP) |=> decel_active)
    else $error("decelerate method not entered");
  a_db_no_drive: assert property ( // [R07]
    dynamic_brake_stop |-> (cmd_velocity == 16'sh0 && !coast_on && !decel_active))
    else $error("dynamic brake while driving");
  a_decel_force: assert property ( // [R08]
    decel_active |-> (decel_force <= OSCL_ESTOP_MAX && decel_force <= $past(motor_max_force)))
    else $error("stop force above limit");
  a_clamp_after: assert property ( // [R09]
    $rose(zero_clamp_on) |-> ($past(r_ff.st) == OSCL_ST_DECEL &&
      r_ff.clamp_pos == $past(fb_position)))
    else $error("zero clamp not entered from deceleration");
  a_coast_free: assert property ( // [R10]
    coast_on |-> (cmd_velocity == 16'sh0 && !dynamic_brake_stop && !zero_clamp_on))
    else $error("coast while controlling");
  a_force_no_decel: assert property ( // [R11]
    (r_ff.st == OSCL_ST_RUN && force_control) |=> !decel_active)
    else $error("deceleration under force control");
  a_dir_reverse: assert property ( // [R12]
    (r_ff.st == OSCL_ST_RUN && $past(r_ff.st == OSCL_ST_RUN) && r_ff.act_dir &&
     $past(r_ff.act_dir)) |-> cmd_velocity == neg_sat($past(ref_velocity)))
    else $error("reversal not applied to reference");
  a_estop_range: assert property ( // [R14]
    r_ff.estop <= OSCL_ESTOP_MAX)
    else $error("stop force register out of range");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_decel_clamp: cover property (decel_active ##[1:200] zero_clamp_on);
  c_db_hold: cover property (r_ff.st == OSCL_ST_DB ##[1:200] r_ff.st == OSCL_ST_DB_HOLD);
  c_away_back: cover property (r_ff.st != OSCL_ST_RUN && away ##1 r_ff.st == OSCL_ST_RUN);
  c_restart: cover property (wb_ack_o && $past(wb_we_i && adr == OSCL_ADR_CTRL));
endmodule

/* verif/oscl_stage_model.sv */
module oscl_stage_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic signed [15:0] cmd_velocity,
  input wire logic dynamic_brake_stop,
  input wire logic coast_on,
  input wire logic decel_active,
  input wire logic fwd_block,
  input wire logic rev_block,
  output logic signed [15:0] fb_velocity,
  output logic signed [31:0] fb_position,
  output logic forward_limit_input,
  output logic reverse_limit_input,
  output logic enc_a,
  output logic enc_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] v_ff;
  logic signed [31:0] pos_ff;
  // ----------------------------------------------------------------
  // mechanics
  // ----------------------------------------------------------------
  // each stop kind sheds speed at its own pace, so every stop state lasts
  // long enough to be seen; power stage otherwise follows the command at once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      v_ff <= 16'sh0000;
      pos_ff <= 32'sh00000000;
    end else begin
      if (dynamic_brake_stop) begin
        v_ff <= v_ff - (v_ff >>> 2);
      end else if (coast_on) begin
        v_ff <= v_ff - (v_ff >>> 4);
      end else if (decel_active) begin
        v_ff <= (v_ff > 16'sd8) ? v_ff - 16'sd8 : (v_ff < -16'sd8) ? v_ff + 16'sd8 : 16'sh0000;
      end else begin
        v_ff <= cmd_velocity;
      end
      pos_ff <= pos_ff + 32'(v_ff >>> 3);
    end
  end
  // ----------------------------------------------------------------
  // pins: switches are closed (high) while travel is allowed
  // ----------------------------------------------------------------
  assign fb_velocity = v_ff;
  assign fb_position = pos_ff;
  assign forward_limit_input = !fwd_block;
  assign reverse_limit_input = !rev_block;
  assign enc_a = pos_ff[3];
  assign enc_b = pos_ff[3] ^ pos_ff[4];
endmodule

/* verif/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import oscl_pkg::*;
  localparam logic [39:0] M_CODE = {8'h00, 8'h01, 8'h02, 8'h10, 8'h20};
  localparam logic [19:0] M_STOP = 20'h11244;
  localparam logic [19:0] M_HOLD = 20'h12282;
  localparam logic [19:0] M_HST = 20'h45565;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic fwd_block = 1'b0;
  logic rev_block = 1'b0;
  logic forward_limit_input;
  logic reverse_limit_input;
  logic enc_a;
  logic enc_b;
  logic enc_a_out;
  logic enc_b_out;
  logic signed [15:0] ref_velocity = 16'sh0000;
  logic signed [15:0] fb_velocity;
  logic signed [15:0] cmd_velocity;
  logic signed [31:0] fb_position;
  logic force_control = 1'b0;
  logic [9:0] motor_max_force = 10'h12C;
  logic dynamic_brake_stop;
  logic coast_on;
  logic decel_active;
  logic zero_clamp_on;
  logic fwd_overtravel;
  logic rev_overtravel;
  logic [9:0] decel_force;
  int err_count = 0;
  int total_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  oscl_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input), .enc_a_in(enc_a), .enc_b_in(enc_b),
    .enc_a_out(enc_a_out), .enc_b_out(enc_b_out), .ref_velocity(ref_velocity),
    .fb_velocity(fb_velocity), .fb_position(fb_position), .force_control(force_control),
    .motor_max_force(motor_max_force), .cmd_velocity(cmd_velocity),
    .dynamic_brake_stop(dynamic_brake_stop), .coast_on(coast_on), .decel_active(decel_active),
    .decel_force(decel_force), .zero_clamp_on(zero_clamp_on), .fwd_overtravel(fwd_overtravel),
    .rev_overtravel(rev_overtravel));

  oscl_stage_model i_stage (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_velocity(cmd_velocity),
    .dynamic_brake_stop(dynamic_brake_stop), .coast_on(coast_on), .decel_active(decel_active),
    .fwd_block(fwd_block), .rev_block(rev_block), .fb_velocity(fb_velocity),
    .fb_position(fb_position), .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input), .enc_a(enc_a), .enc_b(enc_b));

  // ----------------------------------------------------------------
  // reporting and compares
  // ----------------------------------------------------------------
  task automatic fail(input string msg);
    err_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask

  function automatic logic [3:0] stop_vec();
    return {zero_clamp_on, decel_active, coast_on, dynamic_brake_stop};
  endfunction

  // bounded poll: stop outputs must reach the exact pattern given, one-hot or all zero
  task automatic wait_vec(input logic [3:0] exp, input string msg);
    int n;
    n = 0;
    while (stop_vec() !== exp && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk_word({28'h0, stop_vec()}, {28'h0, exp}, msg);
  endtask

  // ----------------------------------------------------------------
  // wishbone classic master
  // ----------------------------------------------------------------
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) fail("bus answer missing");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] rd;
    wb_xfer(1'b1, adr, wd, sel, rd);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 32'h00000000, 4'hF, rd);
    chk_word(rd, exp, $sformatf("read at %h", adr));
  endtask

  task automatic cfg_apply(input logic [31:0] cfg);
    wr(OSCL_ADR_CFG, cfg, 4'hF);
    wr(OSCL_ADR_CTRL, 32'h00000001, 4'h1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk(OSCL_ADR_CFG, 32'h00000021);
    rd_chk(OSCL_ADR_ACTIVE, 32'h00000021);
    rd_chk(OSCL_ADR_ESTOP, 32'h00000320);
    rd_chk(OSCL_ADR_STATUS, 32'h00000000);
    rd_chk(8'h14, 32'h00000000);
    wr(OSCL_ADR_ESTOP, 32'h000003FF, 4'hF);
    rd_chk(OSCL_ADR_ESTOP, 32'h00000320);
    wr(OSCL_ADR_ESTOP, 32'h000000C8, 4'hF);
    rd_chk(OSCL_ADR_ESTOP, 32'h000000C8);
    wr(OSCL_ADR_STATUS, 32'hFFFFFFFF, 4'hF);
    rd_chk(OSCL_ADR_STATUS, 32'h00000000);
    wr(OSCL_ADR_CFG, 32'h00010288, 4'hF);
    wr(OSCL_ADR_CFG, 32'hFFFFFF33, 4'h1);
    rd_chk(OSCL_ADR_CFG, 32'h00010233);
    rd_chk(OSCL_ADR_ACTIVE, 32'h00000021);
    cfg_apply(32'h00000021);
  endtask

  // every stop code, alternating forward and reverse limits
  task automatic t_methods();
    for (int i = 0; i < 5; i++) begin
      logic signed [15:0] s;
      logic [7:0] code;
      s = (i % 2) ? -16'sd200 : 16'sd200;
      code = M_CODE[39-8*i -: 8];
      cfg_apply({16'h0000, code, 8'h21});
      // last pass limits the stage below the stop force so the cap shows
      motor_max_force <= (i == 4) ? 10'h064 : 10'h12C;
      ref_velocity <= s;
      repeat (4) @(posedge ref_clk);
      if (i % 2) rev_block <= 1'b1;
      else fwd_block <= 1'b1;
      wait_vec(M_STOP[19-4*i -: 4], "stop kind");
      chk_word({31'h0, (i % 2) ? rev_overtravel : fwd_overtravel}, 32'h1, "flag");
      chk_word(32'(cmd_velocity), 32'h0, "cmd in stop");
      if (decel_active === 1'b1) begin
        chk_word({22'h0, decel_force}, (i == 4) ? 32'h064 : 32'h0C8, "force");
      end
      wait_vec(M_HOLD[19-4*i -: 4], "after stop");
      // long enough for the slowest stop to settle into its hold state
      repeat (64) @(posedge ref_clk);
      rd_chk(OSCL_ADR_STATUS, {27'h0, M_HST[18-4*i -: 3], i[0], !i[0]});
      ref_velocity <= -(s >>> 2);
      wait_vec(4'h0, "release");
      @(posedge ref_clk);
      chk_word(32'(cmd_velocity), 32'(-(s >>> 2)), "away cmd");
      fwd_block <= 1'b0;
      rev_block <= 1'b0;
      ref_velocity <= 16'sh0000;
      repeat (8) @(posedge ref_clk);
      chk_word({30'h0, fwd_overtravel, rev_overtravel}, 32'h0, "flags clear");
    end
  endtask

  task automatic t_force();
    cfg_apply(32'h00001021);
    force_control <= 1'b1;
    ref_velocity <= 16'sd200;
    repeat (4) @(posedge ref_clk);
    fwd_block <= 1'b1;
    wait_vec(4'h1, "force stop");
    wait_vec(4'h2, "force hold");
    ref_velocity <= -16'sd50;
    wait_vec(4'h0, "force release");
    fwd_block <= 1'b0;
    force_control <= 1'b0;
    ref_velocity <= 16'sh0000;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_ignore();
    cfg_apply(32'h00000088);
    fwd_block <= 1'b1;
    rev_block <= 1'b1;
    ref_velocity <= 16'sd100;
    repeat (8) @(posedge ref_clk);
    wait_vec(4'h0, "fwd ignored");
    chk_word(32'(cmd_velocity), 32'd100, "fwd free cmd");
    ref_velocity <= -16'sd100;
    repeat (8) @(posedge ref_clk);
    wait_vec(4'h0, "rev ignored");
    chk_word(32'(cmd_velocity), 32'(-16'sd100), "rev free cmd");
    fwd_block <= 1'b0;
    rev_block <= 1'b0;
    ref_velocity <= 16'sh0000;
    cfg_apply(32'h00000021);
  endtask

  task automatic t_dir();
    // motor phase is taken as already correct before reversal
    cfg_apply(32'h00010021);
    ref_velocity <= 16'sd100;
    repeat (4) @(posedge ref_clk);
    chk_word(32'(cmd_velocity), 32'(-16'sd100), "reversed cmd");
    ref_velocity <= 16'sh0000;
    repeat (10) @(posedge ref_clk);
    chk_word({30'h0, enc_a_out, enc_b_out}, {30'h0, enc_a, enc_b}, "encoder polarity");
    cfg_apply(32'h00000021);
  endtask

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_methods();
    t_force();
    t_ignore();
    t_dir();
    print_verdict();
  end

  // whole run needs under a thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail("watchdog expired");
    print_verdict();
  end
endmodule
